// [capacitive_touch_acquisition_test.sv]
// Self-checking bench for the touch acquisition unit.
`timescale 1ns/10ps
`include "ctu_params.svh"
module capacitive_touch_acquisition_test;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] touched = 32'h00000000;
  logic        pready, pslverr, sense_high, charge_on, vsel, rsel;
  logic        change_event, dma_in_req, dma_out_req, rerr;
  logic [31:0] prdata, rdata;
  logic [4:0]  sensor_select, trim;
  logic [7:0]  source_on;
  logic        src_seen = 1'b0;
  logic [31:0] dis_tab [5];
  logic [15:0] refs [3];
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;
  int          hits;
  ctu_pkg::ctu_discharge_t dc;

  ctu_top u_dut (
    .clock(clock), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sense_high(sense_high),
    .sensor_select(sensor_select), .charge_on(charge_on),
    .source_on(source_on), .reference_voltage_select(vsel),
    .reference_resistor_select(rsel), .discharge_trim(trim),
    .change_event(change_event), .dma_in_req(dma_in_req),
    .dma_out_req(dma_out_req)
  );
  ctu_sensor_model u_sensor (
    .clock(clock), .reset(reset), .charge_on(charge_on),
    .sensor_select(sensor_select), .touched(touched),
    .sense_high(sense_high)
  );

  always #5 clock = ~clock;

  // Hang guard, far above the thousand or so cycles the sequence needs.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      summarize();
    end
    if (charge_on === 1'b1 && source_on === 8'hFF) src_seen <= 1'b1;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen at a rising edge.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask

  task wait_evt;
    for (n = 0; n < 2000 && change_event !== 1'b1; n++) @(posedge clock);
  endtask

  initial begin
    dis_tab = '{32'hFFFFFFFF, 32'h7F7FFFFF, 32'h81820055, 32'h00011500,
                32'h00000000};
    refs = '{16'h1234, 16'h1000, 16'h0800};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    rd(`CTU_OFF_DISCHARGE);
    chk(rdata, `CTU_DIS_RESET);
    // Unmapped place is refused both ways.
    wr(12'h040, 32'hFFFFFFFF);
    chk(32'(rerr), 32'h00000001);
    rd(12'h040);
    chk({rdata[30:0], rerr}, 32'h00000001);
    // Forcing is tried only while idle, never during acquisition.
    for (int i = 0; i < 5; i++) begin
      wr(`CTU_OFF_DISCHARGE, dis_tab[i]);
      repeat (3) @(posedge clock);
      dc = ctu_pkg::ctu_discharge_t'(dis_tab[i] & `CTU_DIS_WMASK);
      rd(`CTU_OFF_DISCHARGE);
      chk(rdata, 32'(dc));
      chk(32'(vsel), 32'(dc.vref_sel));
      chk(32'(rsel), 32'(dc.rref_sel));
      chk(32'(trim), 32'(dc.trim));
      chk(32'(source_on), 32'(dc.source_global_enable ? dc.force_mask : 8'h00));
    end
    // Autonomous sensing on pin 3 with threshold 30.
    wr(`CTU_OFF_DISCHARGE, 32'h008000FF);
    wr(`CTU_OFF_AUTO_PIN, 32'h00000003);
    wr(`CTU_OFF_ACQ_CFG0, 32'h0000001E);
    wr(`CTU_OFF_ACQ_CFG1, 32'h000000FF);
    wr(`CTU_OFF_ACQ_CFG2, 32'h00000005);
    wr(`CTU_OFF_ACQ_CFG3, 32'h00000000);
    wr(`CTU_OFF_CTRL, 32'h00000005);
    repeat (300) @(posedge clock);
    rd(`CTU_OFF_STATUS);
    chk(rdata & 32'h00000003, 32'h00000000);
    touched[3] <= 1'b1;
    wait_evt();
    chk(32'(n < 2000), 32'h00000001);
    rd(`CTU_OFF_STATUS);
    chk(rdata & 32'h00000003, 32'h00000003);
    rd(`CTU_OFF_STATUS);
    chk(rdata & 32'h00000003, 32'h00000001);
    chk(32'(src_seen), 32'h00000001);
    chk(32'(sensor_select), 32'h00000003);
    touched[3] <= 1'b0;
    wait_evt();
    chk(32'(n < 2000), 32'h00000001);
    rd(`CTU_OFF_STATUS);
    chk(rdata & 32'h00000001, 32'h00000000);
    wr(`CTU_OFF_CTRL, 32'h00000000);
    repeat (2) @(posedge clock);
    hits = 0;
    repeat (200) begin
      @(posedge clock);
      hits += (charge_on !== 1'b0);
    end
    chk(32'(hits), 32'h00000000);
    // DMA sensing on pin 5; three words in before any is read back.
    wr(`CTU_OFF_PIN_FUNC0, 32'h00000020);
    wr(`CTU_OFF_PIN_FUNC1, 32'h00000000);
    wr(`CTU_OFF_PIN_FUNC2, 32'h00000000);
    wr(`CTU_OFF_CTRL, 32'h00000002);
    for (int k = 0; k < 3; k++) begin
      for (n = 0; n < 2000 && dma_in_req !== 1'b1; n++) @(posedge clock);
      chk(32'(n < 2000), 32'h00000001);
      chk(32'(sensor_select), 32'h00000005);
      wr(`CTU_OFF_STATE_IN, {16'h0000, refs[k]});
      repeat (2) @(posedge clock);
    end
    rd(`CTU_OFF_STATUS);
    chk(rdata & 32'h00000004, 32'h00000004);
    for (int k = 0; k < 3; k++) begin
      for (n = 0; n < 2000 && dma_out_req !== 1'b1; n++) @(posedge clock);
      rd(`CTU_OFF_STATE_OUT);
      chk(32'(rdata[15:0]), 32'(refs[k] - 16'h0001));
      chk(32'(rdata[31:16] inside {[3:12]}), 32'h00000001);
      repeat (2) @(posedge clock);
    end
    repeat (3) @(posedge clock);
    chk(32'(dma_out_req), 32'h00000000);
    wr(`CTU_OFF_CTRL, 32'h00000000);
    summarize();
  end
endmodule

// [ctu_buf.sv]
// Two-entry valid/ready buffer for updated state words.
`timescale 1ns/10ps
module ctu_buf #(
  parameter int WIDTH = 32
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  logic [WIDTH-1:0] slot [2];
  logic [WIDTH-1:0] next_slot [2];
  logic [1:0]       fill;
  logic [1:0]       next_fill;
  logic             push;
  logic             pop;

  // Slot 0 is always the head, so the output is a plain register.
  always_comb begin
    push         = in_valid && in_ready;
    pop          = out_valid && out_ready;
    next_slot[0] = slot[0];
    next_slot[1] = slot[1];
    next_fill    = fill;
    if (pop) begin
      next_slot[0] = slot[1];
    end
    if (push) begin
      if (fill == 2'h0 || (fill == 2'h1 && pop)) begin
        next_slot[0] = in_data;
      end else begin
        next_slot[1] = in_data;
      end
    end
    next_fill = fill + {1'b0, push} - {1'b0, pop};
  end

  // Flags are registered so that full and empty never glitch.
  always_ff @(posedge clock) begin
    if (reset) begin
      fill      <= 2'h0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      fill      <= next_fill;
      in_ready  <= (next_fill != 2'h2);
      out_valid <= (next_fill != 2'h0);
    end
    slot[0] <= next_slot[0];
    slot[1] <= next_slot[1];
  end

  assign out_data = slot[0];
endmodule

// [ctu_params.svh]
// Register map, field positions, reset values and timing counts.
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH
`define CTU_OFF_CTRL        12'h000
`define CTU_OFF_AUTO_PIN    12'h004
`define CTU_OFF_ACQ_CFG0    12'h008
`define CTU_OFF_ACQ_CFG1    12'h00C
`define CTU_OFF_ACQ_CFG2    12'h010
`define CTU_OFF_ACQ_CFG3    12'h014
`define CTU_OFF_STATUS      12'h018
`define CTU_OFF_PIN_FUNC0   12'h01C
`define CTU_OFF_PIN_FUNC1   12'h020
`define CTU_OFF_PIN_FUNC2   12'h024
`define CTU_OFF_STATE_IN    12'h028
`define CTU_OFF_STATE_OUT   12'h02C
`define CTU_OFF_DISCHARGE   12'h05C
`define CTU_CTRL_AUTO_EN    0
`define CTU_CTRL_DMA_EN     1
`define CTU_CTRL_NOTIFY_EN  2
`define CTU_ST_ACTIVE       0
`define CTU_ST_CHANGED      1
`define CTU_ST_OUT_VALID    2
`define CTU_DIS_FORCE_LSB   24
`define CTU_DIS_SOURCE_GLOBAL_ENABLE        23
`define CTU_DIS_VREF_SEL    17
`define CTU_DIS_RREF_SEL    16
`define CTU_DIS_TRIM_LSB    8
`define CTU_DIS_SRC_LSB     0
`define CTU_DIS_RESET       32'h0000_0000
`define CTU_DIS_WMASK       32'hFF83_1FFF
`define CTU_CFG1_RESET      32'h0000_00FF
`define CTU_PIN_MODE_DMA    3'h1
`define CTU_CLK_NS          10
`define CTU_SETTLE_NS       100
`define CTU_SETTLE_CYC ((`CTU_SETTLE_NS + `CTU_CLK_NS - 1) / `CTU_CLK_NS)
`endif

// [ctu_pkg.sv]
// Types shared by the touch acquisition unit, its checker and its testbench.
package ctu_pkg;
  typedef enum logic [2:0] {
    ctu_idle    = 3'h0,
    ctu_settle  = 3'h1,
    ctu_measure = 3'h3,
    ctu_decide  = 3'h2,
    ctu_req_in  = 3'h7,
    ctu_update  = 3'h5,
    ctu_push    = 3'h4
  } ctu_state_t;

  typedef struct packed {
    logic [7:0] force_mask;
    logic       source_global_enable;
    logic [4:0] zero_a;
    logic       vref_sel;
    logic       rref_sel;
    logic [2:0] zero_b;
    logic [4:0] trim;
    logic [7:0] sources;
  } ctu_discharge_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reference;
  } ctu_word_t;
endpackage

// [ctu_sensor_model.sv]
// Behavioural electrode and comparator model for the touch unit.
`timescale 1ns/10ps
module ctu_sensor_model #(
  parameter int SHORT = 5,
  parameter int LONG  = 60
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        charge_on,
  input  wire logic [4:0]  sensor_select,
  input  wire logic [31:0] touched,
  output logic             sense_high = 1'b0
);
  int   cnt;
  int   next_cnt;
  logic next_sense;

  // A touched electrode holds more charge and takes longer to cross the
  // threshold; the comparator stays low whenever no measure is running.
  always_comb begin
    next_cnt = charge_on ? cnt + 1 : 0;
    next_sense = charge_on &&
                 cnt >= (touched[sensor_select] ? LONG : SHORT);
    if (reset) begin
      next_cnt = 0;
      next_sense = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    cnt <= next_cnt;
    sense_high <= next_sense;
  end
endmodule

// [ctu_top.sv]
// Capacitive touch acquisition unit with APB registers and DMA handshake.
//
// Operation
// - Once enabled, the autonomous sensor is measured over and over.
// - Its active state shows in status, with an optional change event.
// - Autonomous acquisition runs until disabled or reset, pausing while a DMA pin awaits its word or buffer room.
// - After a count on a DMA pin, the unit requests that pin's state word.
// - The count and the received word form an updated output word.
// - A set force bit keeps its discharge source on continuously.
// - Bit 23 switches the whole discharge source circuit on or off.
// - Bit 17 picks band-gap or one third of supply as reference.
// - Bit 16 picks external or internal reference resistor.
// - A 5-bit trim sets the discharge current, 0x00 least, 0x1F most.
// - Each source enable lets its source run during acquisition.
`timescale 1ns/10ps
`include "ctu_params.svh"
module ctu_top #(
  parameter int PINS = 32
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [31:0]            prdata,
  input  wire logic              sense_high,
  output logic [4:0]             sensor_select,
  output logic                   charge_on,
  output logic [7:0]             source_on,
  output logic                   reference_voltage_select,
  output logic                   reference_resistor_select,
  output logic [4:0]             discharge_trim,
  output logic                   change_event,
  output logic                   dma_in_req,
  output logic                   dma_out_req
);
  ctu_pkg::ctu_state_t     state;
  ctu_pkg::ctu_state_t     next_state;
  ctu_pkg::ctu_discharge_t dis;
  ctu_pkg::ctu_discharge_t next_dis;
  ctu_pkg::ctu_word_t      word_in;
  ctu_pkg::ctu_word_t      next_word_in;
  ctu_pkg::ctu_word_t      upd_word;
  ctu_pkg::ctu_word_t      next_upd_word;
  ctu_pkg::ctu_word_t      buf_head;
  logic [2:0]              ctrl;
  logic [2:0]              next_ctrl;
  logic [4:0]              auto_pin;
  logic [4:0]              next_auto_pin;
  logic [31:0]             cfg [4];
  logic [31:0]             next_cfg [4];
  logic [PINS-1:0]         pin_func [3];
  logic [PINS-1:0]         next_pin_func [3];
  logic                    active;
  logic                    next_active;
  logic                    changed;
  logic                    next_changed;
  logic                    in_full;
  logic                    next_in_full;
  logic [15:0]             count;
  logic [15:0]             next_count;
  logic [4:0]              pin;
  logic [4:0]              next_pin;
  logic                    doing_auto;
  logic                    next_doing_auto;
  logic [15:0]             gap;
  logic [15:0]             next_gap;
  logic                    next_pready;
  logic                    next_pslverr;
  logic [31:0]             next_prdata;
  logic                    next_change_event;
  logic [7:0]              next_source_on;
  logic                    wr_done;
  logic                    rd_done;
  logic                    setup;
  logic                    buf_valid;
  logic                    buf_ready;
  logic                    pop_out;
  logic                    change_now;
  logic [4:0]              next_dma_pin;
  logic                    have_dma_pin;

  // Tells whether an offset belongs to the register map.
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      `CTU_OFF_CTRL, `CTU_OFF_AUTO_PIN, `CTU_OFF_ACQ_CFG0,
      `CTU_OFF_ACQ_CFG1, `CTU_OFF_ACQ_CFG2, `CTU_OFF_ACQ_CFG3,
      `CTU_OFF_STATUS, `CTU_OFF_PIN_FUNC0, `CTU_OFF_PIN_FUNC1,
      `CTU_OFF_PIN_FUNC2, `CTU_OFF_STATE_IN, `CTU_OFF_STATE_OUT,
      `CTU_OFF_DISCHARGE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Three pin function bits together give a pin's mode.
  function automatic logic is_dma_pin(input logic [4:0] p);
    is_dma_pin = {pin_func[2][p], pin_func[1][p], pin_func[0][p]}
                 == `CTU_PIN_MODE_DMA;
  endfunction

  // Moves the stored reference one step toward the new count.
  function automatic ctu_pkg::ctu_word_t combine(
    input ctu_pkg::ctu_word_t w,
    input logic [15:0]        c
  );
    combine.count     = c;
    combine.reference = w.reference;
    if (c > w.reference) begin
      combine.reference = w.reference + 16'h0001;
    end else if (c < w.reference) begin
      combine.reference = w.reference - 16'h0001;
    end
  endfunction

  // The slave waits one cycle so that read data leaves a flip-flop.
  always_comb begin
    setup   = psel && !penable;
    wr_done = psel && penable && pready && pwrite && !pslverr;
    rd_done = psel && penable && pready && !pwrite && !pslverr;
    pop_out = rd_done && paddr == `CTU_OFF_STATE_OUT;
    next_pready  = setup;
    next_pslverr = setup && !mapped(paddr);
    next_prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        `CTU_OFF_CTRL:      next_prdata = {29'h0, ctrl};
        `CTU_OFF_AUTO_PIN:  next_prdata = {27'h0, auto_pin};
        `CTU_OFF_ACQ_CFG0:  next_prdata = cfg[0];
        `CTU_OFF_ACQ_CFG1:  next_prdata = cfg[1];
        `CTU_OFF_ACQ_CFG2:  next_prdata = cfg[2];
        `CTU_OFF_ACQ_CFG3:  next_prdata = cfg[3];
        `CTU_OFF_STATUS:    next_prdata = {29'h0, buf_valid, changed,
                                           active};
        `CTU_OFF_PIN_FUNC0: next_prdata = 32'(pin_func[0]);
        `CTU_OFF_PIN_FUNC1: next_prdata = 32'(pin_func[1]);
        `CTU_OFF_PIN_FUNC2: next_prdata = 32'(pin_func[2]);
        `CTU_OFF_STATE_OUT: next_prdata = buf_head;
        `CTU_OFF_DISCHARGE: next_prdata = dis;
        default:            next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  // Software-written configuration; a write to the state word input
  // stands for the DMA delivery the unit asked for.
  always_comb begin
    next_ctrl     = ctrl;
    next_auto_pin = auto_pin;
    next_dis      = dis;
    next_cfg      = cfg;
    next_pin_func = pin_func;
    next_word_in  = word_in;
    next_in_full  = in_full && state != ctu_pkg::ctu_update;
    if (wr_done) begin
      case (paddr)
        `CTU_OFF_CTRL:      next_ctrl = pwdata[2:0];
        `CTU_OFF_AUTO_PIN:  next_auto_pin = pwdata[4:0];
        `CTU_OFF_ACQ_CFG0:  next_cfg[0] = pwdata;
        `CTU_OFF_ACQ_CFG1:  next_cfg[1] = pwdata;
        `CTU_OFF_ACQ_CFG2:  next_cfg[2] = pwdata;
        `CTU_OFF_ACQ_CFG3:  next_cfg[3] = pwdata;
        `CTU_OFF_PIN_FUNC0: next_pin_func[0] = pwdata[PINS-1:0];
        `CTU_OFF_PIN_FUNC1: next_pin_func[1] = pwdata[PINS-1:0];
        `CTU_OFF_PIN_FUNC2: next_pin_func[2] = pwdata[PINS-1:0];
        `CTU_OFF_STATE_IN: begin
          next_word_in = pwdata;
          next_in_full = 1'b1;
        end
        `CTU_OFF_DISCHARGE: next_dis = pwdata & `CTU_DIS_WMASK;
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl        <= 3'h0;
      auto_pin    <= 5'h00;
      dis         <= `CTU_DIS_RESET;
      cfg[0]      <= 32'h0000_0000;
      cfg[1]      <= `CTU_CFG1_RESET;
      cfg[2]      <= 32'h0000_0000;
      cfg[3]      <= 32'h0000_0000;
      pin_func[0] <= '0;
      pin_func[1] <= '0;
      pin_func[2] <= '0;
      word_in     <= 32'h0000_0000;
      in_full     <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      auto_pin <= next_auto_pin;
      dis      <= next_dis;
      cfg      <= next_cfg;
      pin_func <= next_pin_func;
      word_in  <= next_word_in;
      in_full  <= next_in_full;
    end
  end

  // Finds the next DMA-driven pin above the current one, wrapping.
  always_comb begin
    next_dma_pin = pin;
    have_dma_pin = 1'b0;
    for (int i = PINS; i >= 1; i--) begin
      if (is_dma_pin(5'((32'(pin) + i) % PINS))) begin
        next_dma_pin = 5'((32'(pin) + i) % PINS);
        have_dma_pin = 1'b1;
      end
    end
  end

  // Sequencer: the autonomous sensor and the DMA pins take turns.
  always_comb begin
    next_state      = state;
    next_count      = count;
    next_pin        = pin;
    next_doing_auto = doing_auto;
    next_gap        = gap;
    next_active     = active;
    next_upd_word   = upd_word;
    change_now      = 1'b0;
    case (state)
      ctu_pkg::ctu_idle: begin
        next_count = 16'h0000;
        if (gap != 16'h0000) begin
          next_gap = gap - 16'h0001;
        end else if (ctrl[`CTU_CTRL_AUTO_EN] &&
                     !(doing_auto && ctrl[`CTU_CTRL_DMA_EN] &&
                       have_dma_pin)) begin
          next_pin        = auto_pin;
          next_doing_auto = 1'b1;
          next_state      = ctu_pkg::ctu_settle;
        end else if (ctrl[`CTU_CTRL_DMA_EN] && have_dma_pin) begin
          next_pin        = next_dma_pin;
          next_doing_auto = 1'b0;
          next_state      = ctu_pkg::ctu_settle;
        end
      end
      ctu_pkg::ctu_settle: begin
        next_count = count + 16'h0001;
        if (count == 16'(`CTU_SETTLE_CYC - 1)) begin
          next_count = 16'h0000;
          next_state = ctu_pkg::ctu_measure;
        end
      end
      ctu_pkg::ctu_measure: begin
        // The count runs until the sensed line rises or the limit.
        next_count = count + 16'h0001;
        if (sense_high || count == cfg[1][15:0]) begin
          next_state = doing_auto ? ctu_pkg::ctu_decide
                                  : ctu_pkg::ctu_req_in;
        end
      end
      ctu_pkg::ctu_decide: begin
        next_active = count >= cfg[0][15:0];
        change_now  = next_active != active;
        next_gap    = cfg[2][15:0];
        next_state  = ctu_pkg::ctu_idle;
      end
      ctu_pkg::ctu_req_in: begin
        if (in_full) begin
          next_state = ctu_pkg::ctu_update;
        end
      end
      ctu_pkg::ctu_update: begin
        next_upd_word = combine(word_in, count);
        next_state    = ctu_pkg::ctu_push;
      end
      ctu_pkg::ctu_push: begin
        // A full buffer holds the sequencer here, so no word is lost.
        if (buf_ready) begin
          next_gap   = cfg[2][15:0];
          next_state = ctu_pkg::ctu_idle;
        end
      end
      default: next_state = ctu_pkg::ctu_idle;
    endcase
    // Disabling both modes stops any scan at once; words already queued remain.
    if (!ctrl[`CTU_CTRL_AUTO_EN] && !ctrl[`CTU_CTRL_DMA_EN]) begin
      next_state = ctu_pkg::ctu_idle;
      next_gap   = 16'h0000;
    end
    next_changed = change_now ||
                   (changed && !(rd_done &&
                                 paddr == `CTU_OFF_STATUS));
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state      <= ctu_pkg::ctu_idle;
      count      <= 16'h0000;
      pin        <= 5'h00;
      doing_auto <= 1'b0;
      gap        <= 16'h0000;
      active     <= 1'b0;
      changed    <= 1'b0;
      upd_word   <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      count      <= next_count;
      pin        <= next_pin;
      doing_auto <= next_doing_auto;
      gap        <= next_gap;
      active     <= next_active;
      changed    <= next_changed;
      upd_word   <= next_upd_word;
    end
  end

  // Current source gating: global enable overrides force and enables.
  always_comb begin
    next_source_on = 8'h00;
    if (dis.source_global_enable) begin
      next_source_on = dis.force_mask |
                       (dis.sources &
                        {8{state == ctu_pkg::ctu_measure}});
    end
    next_change_event = change_now && ctrl[`CTU_CTRL_NOTIFY_EN];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      source_on                 <= 8'h00;
      reference_voltage_select  <= 1'b0;
      reference_resistor_select <= 1'b0;
      discharge_trim            <= 5'h00;
      change_event              <= 1'b0;
      sensor_select             <= 5'h00;
      charge_on                 <= 1'b0;
      dma_in_req                <= 1'b0;
    end else begin
      source_on                 <= next_source_on;
      reference_voltage_select  <= dis.vref_sel;
      reference_resistor_select <= dis.rref_sel;
      discharge_trim            <= dis.trim;
      change_event              <= next_change_event;
      sensor_select             <= next_pin;
      charge_on                 <= next_state == ctu_pkg::ctu_measure;
      dma_in_req                <= next_state == ctu_pkg::ctu_req_in &&
                                   !next_in_full;
    end
  end

  // Updated words queue here until the outgoing DMA channel reads them.
  ctu_buf #(
    .WIDTH (32)
  ) u_out_buf (
    .clock     (clock),
    .reset     (reset),
    .in_valid  (state == ctu_pkg::ctu_push),
    .in_ready  (buf_ready),
    .in_data   (upd_word),
    .out_valid (buf_valid),
    .out_ready (pop_out),
    .out_data  (buf_head)
  );

  assign dma_out_req = buf_valid;
endmodule

// [ctu_top_chk.sv]
// Concurrent checks on the ports of the touch acquisition unit.
`timescale 1ns/10ps
`include "ctu_params.svh"
module ctu_top_chk #(
  parameter int PINS = 32
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        sense_high,
  input wire logic [4:0]  sensor_select,
  input wire logic        charge_on,
  input wire logic [7:0]  source_on,
  input wire logic        reference_voltage_select,
  input wire logic        reference_resistor_select,
  input wire logic [4:0]  discharge_trim,
  input wire logic        change_event,
  input wire logic        dma_in_req,
  input wire logic        dma_out_req
);
  logic [31:0]             dis_q;
  logic [31:0]             next_dis_q;
  logic                    notify_q;
  logic                    next_notify_q;
  logic                    acc_wr;
  logic                    mapped;
  logic [7:0]              allowed;
  logic [7:0]              forced;
  ctu_pkg::ctu_discharge_t dc;

  // Shadow settings; only writes completed with pready count, as in the slave.
  assign acc_wr = psel && penable && pready && pwrite;
  always_comb begin
    next_dis_q = dis_q;
    next_notify_q = notify_q;
    if (reset) begin
      next_dis_q = `CTU_DIS_RESET;
      next_notify_q = 1'b0;
    end else if (acc_wr && paddr == `CTU_OFF_DISCHARGE) begin
      next_dis_q = pwdata & `CTU_DIS_WMASK;
    end else if (acc_wr && paddr == `CTU_OFF_CTRL) begin
      next_notify_q = pwdata[`CTU_CTRL_NOTIFY_EN];
    end
  end
  always_ff @(posedge clock) begin
    dis_q <= next_dis_q;
    notify_q <= next_notify_q;
  end

  // Sources that may conduct, and those that must, from the shadow.
  assign dc = dis_q;
  assign allowed = dc.source_global_enable ? (dc.force_mask | dc.sources) : 8'h00;
  assign forced = dc.source_global_enable ? dc.force_mask : 8'h00;
  assign mapped = (paddr <= `CTU_OFF_STATE_OUT && paddr[1:0] == 2'h0) ||
                  paddr == `CTU_OFF_DISCHARGE;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Settings unchanged for two cycles, so registered copies have caught up.
  sequence s_held;
    $stable(dis_q) && dis_q == $past(dis_q, 2);
  endsequence

  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("ready missing in first access cycle");
  AST_APB_ERR: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match the address map");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside a response");
  AST_DIS_READ: assert property (
    pready && !pwrite && paddr == `CTU_OFF_DISCHARGE |-> prdata == dis_q)
    else $error("discharge register read back wrong");
  AST_VREF_COPY: assert property (
    s_held |-> reference_voltage_select == dc.vref_sel)
    else $error("voltage reference select differs from bit 17");
  AST_RREF_COPY: assert property (
    s_held |-> reference_resistor_select == dc.rref_sel)
    else $error("resistor select differs from bit 16");
  AST_TRIM_COPY: assert property (
    s_held |-> discharge_trim == dc.trim)
    else $error("trim output differs from trim field");
  AST_SRC_GATE: assert property (
    s_held |-> (source_on & ~allowed) == 8'h00)
    else $error("source on without enable, force or global enable");
  AST_SRC_FORCE: assert property (
    s_held |-> (source_on & forced) == forced)
    else $error("forced source not on");
  AST_EVT_PULSE: assert property (
    change_event |-> (notify_q || $past(notify_q)) ##1 !change_event)
    else $error("change event unrequested or longer than one cycle");
  AST_IN_DROP: assert property (
    acc_wr && paddr == `CTU_OFF_STATE_IN && dma_in_req |-> ##[1:2] !dma_in_req)
    else $error("word request stays up after the word arrived");

  CV_EVT: cover property (change_event);
  CV_ERR: cover property (pready && pslverr);
  CV_IN: cover property ($fell(dma_in_req));
  CV_OUT: cover property (dma_out_req && pready && !pwrite &&
                          paddr == `CTU_OFF_STATE_OUT);
endmodule

bind ctu_top ctu_top_chk #(.PINS(PINS)) u_chk (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .sense_high(sense_high),
  .sensor_select(sensor_select), .charge_on(charge_on),
  .source_on(source_on), .discharge_trim(discharge_trim),
  .reference_voltage_select(reference_voltage_select),
  .reference_resistor_select(reference_resistor_select),
  .change_event(change_event), .dma_in_req(dma_in_req),
  .dma_out_req(dma_out_req)
);
